//--- rtl/sbsl_regs.vh
`ifndef SBSL_REGS_VH
`define SBSL_REGS_VH

// Byte offsets of the register map.
`define SBSL_OFS_CTRL 6'h00
`define SBSL_OFS_ACCEL 6'h04
`define SBSL_OFS_DECEL 6'h08
`define SBSL_OFS_BAND_BASE 6'h10
`define SBSL_OFS_BAND_LAST 6'h2C
`define SBSL_OFS_ACTIVE 6'h30
`define SBSL_OFS_SKIPPED 6'h34
`define SBSL_OFS_SETPOINT 6'h38
`define SBSL_OFS_STATUS 6'h3C

// Control register fields.
`define SBSL_CTRL_RATE_EN 0
`define SBSL_CTRL_LOCAL 1
`define SBSL_CTRL_COMMS 2
`define SBSL_CTRL_W 3

// Status register fields.
`define SBSL_STAT_HOLD 0
`define SBSL_STAT_RATE_EN 1

// Reset values.
`define SBSL_RST_CTRL 3'h0
`define SBSL_RST_ACCEL 16'h0100
`define SBSL_RST_DECEL 16'h0100
`define SBSL_RST_BAND 16'h0000

// Rate limit steps are applied once per update period.
`define SBSL_CLK_MHZ 100
`define SBSL_UPDATE_US 1000
`define SBSL_UPDATE_CYC (`SBSL_UPDATE_US * `SBSL_CLK_MHZ)
`define SBSL_TICK_W 17

// Largest magnitude that a 16-bit signed demand can hold.
`define SBSL_MAG_MAX 18'sh07FFF

`endif

//--- rtl/sbsl_band.v
`timescale 1ns/10ps
`include "sbsl_regs.vh"

module sbsl_band (
  input wire signed [15:0] demand_i,
  input wire [15:0] centre_i,
  input wire [15:0] width_i,
  input wire [15:0] width1_i,
  output reg signed [15:0] demand_o
);

  reg [15:0] w;
  reg signed [17:0] mag;
  reg signed [17:0] lo;
  reg signed [17:0] hi;
  reg signed [17:0] m;
  reg signed [17:0] neg;

  always @* begin
    w = (width_i == 16'h0000) ? width1_i : width_i;
    // Compare the magnitude so both directions see the same band.
    mag = demand_i[15] ? -{{2{demand_i[15]}}, demand_i} : {{2{demand_i[15]}}, demand_i};
    lo = $signed({2'b00, centre_i}) - $signed({3'b000, w[15:1]});
    hi = $signed({2'b00, centre_i}) + $signed({3'b000, w[15:1]});
    if (hi > `SBSL_MAG_MAX) begin
      hi = `SBSL_MAG_MAX;
    end
    m = mag;
    if ((centre_i != 16'h0000) && (mag > lo) && (mag < hi)) begin
      if ((mag - lo) <= (hi - mag)) begin
        m = (lo < 18'sh00000) ? 18'sh00000 : lo;
      end else begin
        m = hi;
      end
    end
    neg = -m;
    demand_o = demand_i[15] ? neg[15:0] : m[15:0];
  end

endmodule // sbsl_band

//--- rtl/sbsl_top.v
`timescale 1ns/10ps
`include "sbsl_regs.vh"

module sbsl_top #(
  parameter UPDATE_CYC = `SBSL_UPDATE_CYC
) (
  input wire clock_i,
  input wire rstn_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire signed [15:0] operator_keypad_ref_i,
  input wire signed [15:0] app_ref_i,
  input wire signed [15:0] comms_ref_i,
  input wire hold_i,
  output reg signed [15:0] active_ref_o,
  output reg signed [15:0] setpoint_o,
  output reg hold_active_o
);

  localparam integer UPDATE_LAST_I = UPDATE_CYC - 1;
  localparam [`SBSL_TICK_W-1:0] UPDATE_LAST = UPDATE_LAST_I[`SBSL_TICK_W-1:0];

  // Bus slave state.
  reg [5:0] addr_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg addr_ok_r;

  // Software registers.
  reg [`SBSL_CTRL_W-1:0] ctrl_r;
  reg [15:0] accel_r;
  reg [15:0] decel_r;
  reg [15:0] band_w_r [0:3];
  reg [15:0] band_c_r [0:3];

  // Datapath state.
  reg signed [15:0] skipped_r;
  reg [`SBSL_TICK_W-1:0] tick_cnt_r;
  reg tick_r;

  wire ahb_go;
  wire rate_en;
  wire signed [15:0] chain [0:4];

  integer i;

  // True when the offset falls in the band block; shared by the read and write decoders.
  function is_band;
    input [5:0] a;
    begin
      is_band = (a >= `SBSL_OFS_BAND_BASE) && (a <= `SBSL_OFS_BAND_LAST);
    end
  endfunction

  // Band number of an offset in the band block.
  function [1:0] band_idx;
    input [5:0] a;
    reg [5:0] d;
    begin
      d = a - `SBSL_OFS_BAND_BASE;
      band_idx = d[4:3];
    end
  endfunction

  assign ahb_go = hsel_i && htrans_i[1] && hready_i;
  assign rate_en = ctrl_r[`SBSL_CTRL_RATE_EN];

  // Address phase capture. Reads take one wait state so that read data
  // always come from a flip-flop and never see a half-written register.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r <= 6'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_ok_r <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hreadyout_o <= 1'b1;
      end else if (ahb_go) begin
        addr_r <= haddr_i[5:0];
        // Out-of-range or misaligned offsets must not alias a register.
        addr_ok_r <= (haddr_i[31:6] == 26'h0000000) && (haddr_i[1:0] == 2'b00);
        wr_pend_r <= hwrite_i && (haddr_i[31:6] == 26'h0000000);
        rd_pend_r <= !hwrite_i;
        hreadyout_o <= hwrite_i;
      end else if (hready_i) begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Register writes land at the end of the data phase.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= `SBSL_RST_CTRL;
      accel_r <= `SBSL_RST_ACCEL;
      decel_r <= `SBSL_RST_DECEL;
      for (i = 0; i < 4; i = i + 1) begin
        band_w_r[i] <= `SBSL_RST_BAND;
        band_c_r[i] <= `SBSL_RST_BAND;
      end
    end else if (wr_pend_r && addr_ok_r && hready_i) begin
      if (addr_r == `SBSL_OFS_CTRL) begin
        ctrl_r <= hwdata_i[`SBSL_CTRL_W-1:0];
      end else if (addr_r == `SBSL_OFS_ACCEL) begin
        accel_r <= hwdata_i[15:0];
      end else if (addr_r == `SBSL_OFS_DECEL) begin
        decel_r <= hwdata_i[15:0];
      end else if (is_band(addr_r)) begin
        if (addr_r[2]) begin
          band_c_r[band_idx(addr_r)] <= hwdata_i[15:0];
        end else begin
          band_w_r[band_idx(addr_r)] <= hwdata_i[15:0];
        end
      end
    end
  end

  // Read data are loaded in the wait cycle; unmapped offsets read zero.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_o <= 32'h00000000;
    end else if (rd_pend_r) begin
      if (!addr_ok_r) begin
        hrdata_o <= 32'h00000000;
      end else if (addr_r == `SBSL_OFS_CTRL) begin
        hrdata_o <= {29'h00000000, ctrl_r};
      end else if (addr_r == `SBSL_OFS_ACCEL) begin
        hrdata_o <= {16'h0000, accel_r};
      end else if (addr_r == `SBSL_OFS_DECEL) begin
        hrdata_o <= {16'h0000, decel_r};
      end else if (is_band(addr_r)) begin
        if (addr_r[2]) begin
          hrdata_o <= {16'h0000, band_c_r[band_idx(addr_r)]};
        end else begin
          hrdata_o <= {16'h0000, band_w_r[band_idx(addr_r)]};
        end
      end else if (addr_r == `SBSL_OFS_ACTIVE) begin
        hrdata_o <= {{16{active_ref_o[15]}}, active_ref_o};
      end else if (addr_r == `SBSL_OFS_SKIPPED) begin
        hrdata_o <= {{16{skipped_r[15]}}, skipped_r};
      end else if (addr_r == `SBSL_OFS_SETPOINT) begin
        hrdata_o <= {{16{setpoint_o[15]}}, setpoint_o};
      end else if (addr_r == `SBSL_OFS_STATUS) begin
        hrdata_o <= {30'h00000000, rate_en, hold_active_o};
      end else begin
        hrdata_o <= 32'h00000000;
      end
    end
  end

  // Reference source selection; local wins over fieldbus and terminals.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_ref_o <= 16'h0000;
    end else if (ctrl_r[`SBSL_CTRL_LOCAL]) begin
      active_ref_o <= operator_keypad_ref_i;
    end else if (ctrl_r[`SBSL_CTRL_COMMS]) begin
      active_ref_o <= comms_ref_i;
    end else begin
      active_ref_o <= app_ref_i;
    end
  end

  // Four bands in series; a band edge can never lie inside an earlier
  // band's span only if software keeps the bands apart.
  assign chain[0] = active_ref_o;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_band
      sbsl_band u_band (
        .demand_i(chain[g]),
        .centre_i(band_c_r[g]),
        .width_i(band_w_r[g]),
        .width1_i(band_w_r[0]),
        .demand_o(chain[g+1])
      );
    end
  endgenerate

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      skipped_r <= 16'h0000;
    end else begin
      skipped_r <= chain[4];
    end
  end

  // Update period that scales the rate steps.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= {`SBSL_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= UPDATE_LAST) begin
      tick_cnt_r <= {`SBSL_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Rate limiter. A demand of opposite sign first decelerates to zero,
  // then accelerates away, so each limit governs its own half of the move.
  reg signed [17:0] sp_x;
  reg signed [17:0] goal;
  reg signed [17:0] sp_mag;
  reg signed [17:0] goal_mag;
  reg signed [17:0] step;
  reg signed [17:0] sp_nxt;

  always @* begin
    sp_x = {{2{setpoint_o[15]}}, setpoint_o};
    goal = {{2{skipped_r[15]}}, skipped_r};
    if ((setpoint_o != 16'h0000) && (skipped_r[15] != setpoint_o[15])) begin
      goal = 18'sh00000;
    end
    sp_mag = (sp_x < 18'sh00000) ? -sp_x : sp_x;
    goal_mag = (goal < 18'sh00000) ? -goal : goal;
    if (goal_mag > sp_mag) begin
      step = $signed({2'b00, accel_r});
    end else begin
      step = $signed({2'b00, decel_r});
    end
    // Stepping from the stored value means a released hold resumes ramping.
    if (goal > sp_x) begin
      sp_nxt = ((goal - sp_x) > step) ? (sp_x + step) : goal;
    end else begin
      sp_nxt = ((sp_x - goal) > step) ? (sp_x - step) : goal;
    end
  end

  // Hold is a level from braking logic on this clock, expected to be short.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      setpoint_o <= 16'h0000;
      hold_active_o <= 1'b0;
    end else begin
      hold_active_o <= hold_i;
      if (hold_i) begin
        setpoint_o <= setpoint_o;
      end else if (!rate_en) begin
        setpoint_o <= skipped_r;
      end else if (tick_r) begin
        setpoint_o <= sp_nxt[15:0];
      end
    end
  end

endmodule // sbsl_top

//--- tb/sbsl_props.sv
`timescale 1ns/10ps
module sbsl_props (
  input wire clock_i,
  input wire rstn_i,
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire signed [15:0] operator_keypad_ref_i,
  input wire signed [15:0] app_ref_i,
  input wire signed [15:0] comms_ref_i,
  input wire hold_i,
  input wire signed [15:0] active_ref_o,
  input wire signed [15:0] setpoint_o,
  input wire hold_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire rd_go = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  wire wr_go = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_go |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_go |=> hreadyout_o)
    else $error("write stalled");
  a_ready_back: assert property (!hreadyout_o |=> hreadyout_o)
    else $error("ready low too long");
  a_active_src: assert property ($past(rstn_i) |-> active_ref_o == $past(app_ref_i) ||
    active_ref_o == $past(operator_keypad_ref_i) || active_ref_o == $past(comms_ref_i))
    else $error("active reference from no source");
  a_hold_freeze: assert property (hold_i |=> $stable(setpoint_o))
    else $error("setpoint moved during hold");
  a_hold_span: assert property (hold_i [*2] |=> setpoint_o == $past(setpoint_o, 2))
    else $error("setpoint drifted over hold");
  a_hold_flag: assert property ($rose(hold_i) |=> hold_active_o)
    else $error("hold not reported");
  c_read: cover property (rd_go);
  c_write: cover property (wr_go);
  c_hold: cover property (hold_i [*3]);
endmodule // sbsl_props

bind sbsl_top sbsl_props u_props (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .operator_keypad_ref_i(operator_keypad_ref_i), .app_ref_i(app_ref_i),
  .comms_ref_i(comms_ref_i), .hold_i(hold_i), .active_ref_o(active_ref_o),
  .setpoint_o(setpoint_o), .hold_active_o(hold_active_o));

//--- tb/sbsl_brake_model.sv
`timescale 1ns/10ps
module sbsl_brake_model #(
  parameter HOLD_CYC = 25
) (
  input wire clock_i,
  input wire overvolt_i,
  output wire hold_o
);
  integer left_r = 0;
  // A short fixed hold per overvoltage event, as a dump into the resistor would take.
  always @(posedge clock_i) begin
    if (overvolt_i) left_r <= HOLD_CYC;
    else if (left_r > 0) left_r <= left_r - 1;
  end
  assign hold_o = (left_r > 0);
endmodule // sbsl_brake_model

//--- tb/setpoint_skip_band_slew_limiter_tb_top.sv
`timescale 1ns/10ps
module setpoint_skip_band_slew_limiter_tb_top;
  localparam signed [15:0] ACC = 16'sh0064;
  localparam signed [15:0] DEC = 16'sh012C;
  reg clock_i = 1'b0;
  reg rstn_i = 1'b0;
  reg hsel = 1'b0, hwrite = 1'b0, ovr = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg signed [15:0] kp = 16'h0064, app = 16'h00C8, cm = 16'h012C;
  wire [31:0] hrdata;
  wire hready, hresp, hact, hold;
  wire signed [15:0] active, sp;
  integer failures = 0, tests_run = 0, cycles = 0;
  reg [31:0] d;
  always #5 clock_i = ~clock_i;
  sbsl_brake_model #(.HOLD_CYC(25)) u_brake (.clock_i(clock_i), .overvolt_i(ovr), .hold_o(hold));
  sbsl_top #(.UPDATE_CYC(10)) uut (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .operator_keypad_ref_i(kp), .app_ref_i(app), .comms_ref_i(cm), .hold_i(hold),
    .active_ref_o(active), .setpoint_o(sp), .hold_active_o(hact));
  task complete_run;
    begin
      $display("tests_run %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Returns just after the first rising edge at which hready is sampled high.
  task wait_ready;
    begin
      @(posedge clock_i);
      while (hready !== 1'b1) @(posedge clock_i);
    end
  endtask
  task xfer(input wr, input [31:0] a, input [31:0] wd);
    begin
      @(posedge clock_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      d = hrdata;
    end
  endtask
  task src(input [31:0] c, input [15:0] e);
    begin
      xfer(1'b1, 32'h00, c);
      xfer(1'b0, 32'h30, 32'h0);
      check(d[15:0], e);
      check(active, e);
    end
  endtask
  task pass(input [15:0] dm, input [15:0] e);
    begin
      @(posedge clock_i);
      app <= dm;
      repeat (5) @(posedge clock_i);
      @(negedge clock_i);
      check(sp, e);
    end
  endtask
  task ramp(input signed [15:0] goal, input integer hold_at);
    reg signed [15:0] prev, ev;
    reg hold_q;
    integer i;
    begin
      @(posedge clock_i);
      prev = sp;
      hold_q = hold;
      app <= goal;
      for (i = 0; i < 400 && sp !== goal; i = i + 1) begin
        @(posedge clock_i);
        ovr <= (i == hold_at);
        @(negedge clock_i);
        if (sp !== prev) begin
          ev = (goal > prev) ? ((goal - prev > ACC) ? prev + ACC : goal)
                             : ((prev - goal > DEC) ? prev - DEC : goal);
          check(sp, ev);
          prev = sp;
        end
        check({15'h0000, hact}, {15'h0000, hold_q});
        hold_q = hold;
      end
      check(sp, goal);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    xfer(1'b0, 32'h04, 32'h0);
    check(d[15:0], 16'h0100);
    xfer(1'b0, 32'h08, 32'h0);
    check(d[15:0], 16'h0100);
    xfer(1'b0, 32'h44, 32'h0);
    check(d[15:0], 16'h0000);
    src(32'h0, 16'h00C8);
    src(32'h4, 16'h012C);
    src(32'h6, 16'h0064);
    src(32'h0, 16'h00C8);
    xfer(1'b1, 32'h10, 32'h10);
    xfer(1'b1, 32'h14, 32'h3E8);
    xfer(1'b1, 32'h18, 32'h40);
    xfer(1'b1, 32'h2C, 32'h7D0);
    pass(16'h03EB, 16'h03F0);
    pass(16'hFC15, 16'hFC10);
    pass(16'h03E3, 16'h03E0);
    pass(16'h07D2, 16'h07D8);
    pass(16'h000A, 16'h000A);
    pass(16'h04B0, 16'h04B0);
    xfer(1'b1, 32'h14, 32'h0);
    xfer(1'b1, 32'h2C, 32'h0);
    pass(16'h0000, 16'h0000);
    xfer(1'b1, 32'h04, 32'h64);
    xfer(1'b1, 32'h08, 32'h12C);
    xfer(1'b1, 32'h00, 32'h1);
    ramp(16'sh01F4, 15);
    ramp(16'sh0064, -1);
    xfer(1'b0, 32'h3C, 32'h0);
    check(d[15:0], 16'h0002);
    xfer(1'b0, 32'h34, 32'h0);
    check(d[15:0], 16'h0064);
    xfer(1'b0, 32'h38, 32'h0);
    check(d[15:0], 16'h0064);
    complete_run;
  end
endmodule // setpoint_skip_band_slew_limiter_tb_top
